// file: design/odsm_div_if.sv
// Interface carrying one divider channel's controls and results.
`timescale 1ns/10ps
interface odsm_div_if;
  import odsm_pkg::*;
  logic                run;
  logic                sync_hold;
  logic                sr_en;
  logic [CH_DIV_W-1:0] ch_div;
  logic [SR_DIV_W-1:0] sr_div;
  logic [DLY_W-1:0]    static_dly;
  logic [DLY_W-1:0]    sr_dly;
  logic                tap;
  logic                clk_out;
  logic                rise;
  modport ctrl (output run, sync_hold, sr_en, ch_div, sr_div, static_dly,
                sr_dly, input tap, clk_out, rise);
  modport div  (input run, sync_hold, sr_en, ch_div, sr_div, static_dly,
                sr_dly, output tap, clk_out, rise);
endinterface

// file: design/odsm_divider.sv
// One channel divider with optional SYSREF cascade and digital delays.
`timescale 1ns/10ps
module odsm_divider
  import odsm_pkg::*;
#(
  parameter bit HAS_SR = 1'b1
)(
  input wire logic clk,
  input wire logic resetn,
  odsm_div_if.div  dif
);
  localparam int SR_LINE = (1 << DLY_W) - 1;

  logic [CH_DIV_W-1:0] chd_cnt_r;
  logic [CH_DIV_W-1:0] chd_last;
  logic [CH_DIV_W-1:0] chd_half;
  logic [SR_DIV_W-1:0] srd_cnt_r;
  logic [SR_DIV_W-1:0] srd_last;
  logic [SR_DIV_W-1:0] srd_half;
  logic [DLY_W-1:0]    dly_cnt_r;
  logic                st_out_r;
  logic [SR_LINE-1:0]  sr_line_r;
  logic [SR_LINE:0]    sr_taps;
  logic                out_r;
  logic                out_d_r;
  logic                hold;
  logic                dly_done;
  logic                chd_en;
  logic                chd_tick;
  logic                chd_hi;
  logic                srd_hi;
  logic                use_sr;

  assign hold     = !resetn || !dif.run || dif.sync_hold;
  assign use_sr   = HAS_SR && dif.sr_en;
  assign dly_done = (dly_cnt_r >= dif.static_dly);
  assign chd_en   = !hold && dly_done;

  // Ratios 0 and 1 both leave the output high, as one clock cannot pass
  // a full-rate clock; otherwise the high phase is the first half period.
  assign chd_last = (dif.ch_div > CH_DIV_W'(1)) ? dif.ch_div - CH_DIV_W'(1)
                                                : '0;
  assign chd_half = (dif.ch_div == '0) ? CH_DIV_W'(1)
                  : {1'b0, dif.ch_div[CH_DIV_W-1:1]}
                    + {{(CH_DIV_W-1){1'b0}}, dif.ch_div[0]};
  assign srd_last = (dif.sr_div > SR_DIV_W'(1)) ? dif.sr_div - SR_DIV_W'(1)
                                                : '0;
  assign srd_half = (dif.sr_div == '0) ? SR_DIV_W'(1)
                  : {1'b0, dif.sr_div[SR_DIV_W-1:1]}
                    + {{(SR_DIV_W-1){1'b0}}, dif.sr_div[0]};

  // Twelve-bit channel division, one period per ratio.
  always_ff @(posedge clk)
  begin
    if (!chd_en || chd_cnt_r >= chd_last)
      chd_cnt_r <= '0;
    else
      chd_cnt_r <= chd_cnt_r + CH_DIV_W'(1);
  end
  assign chd_tick = chd_en && (chd_cnt_r >= chd_last);
  assign chd_hi   = chd_en && (chd_cnt_r < chd_half);

  // Cascade advances once per channel period.
  always_ff @(posedge clk)
  begin
    if (hold || !use_sr)
      srd_cnt_r <= '0;
    else if (chd_tick)
    begin
      if (srd_cnt_r >= srd_last)
        srd_cnt_r <= '0;
      else
        srd_cnt_r <= srd_cnt_r + SR_DIV_W'(1);
    end
  end
  assign srd_hi = chd_en && (srd_cnt_r < srd_half);

  // Static digital delay holds back the divider start.
  always_ff @(posedge clk)
  begin
    if (hold)
      dly_cnt_r <= DLY_RST;
    else if (!dly_done)
      dly_cnt_r <= dly_cnt_r + DLY_W'(1);
  end

  always_ff @(posedge clk)
  begin
    if (hold)
      st_out_r <= 1'b0;
    else
      st_out_r <= use_sr ? srd_hi : chd_hi;
  end

  // SYSREF digital delay line, one tap per cycle.
  always_ff @(posedge clk)
  begin
    if (hold)
      sr_line_r <= '0;
    else
      sr_line_r <= {sr_line_r[SR_LINE-2:0], st_out_r};
  end
  assign sr_taps = {sr_line_r, st_out_r};

  always_ff @(posedge clk)
  begin
    if (hold)
      out_r <= 1'b0;
    else
      out_r <= use_sr ? sr_taps[dif.sr_dly] : st_out_r;
  end

  always_ff @(posedge clk)
  begin
    if (hold)
      out_d_r <= 1'b0;
    else
      out_d_r <= out_r;
  end

  assign dif.tap     = use_sr && st_out_r;
  assign dif.clk_out = out_r;
  assign dif.rise    = out_r && !out_d_r;
endmodule

// file: design/odsm_pkg.sv
// Package of constants and types for the output divider and mute block.
package odsm_pkg;
  localparam int CH_DIV_W     = 12;
  localparam int SR_DIV_W     = 20;
  localparam int NUM_CH       = 16;
  localparam int NUM_DIV      = 11;
  localparam int NUM_SRC      = 6;
  localparam int NUM_SR       = 7;
  localparam int DLY_W        = 8;
  localparam logic [CH_DIV_W-1:0] CH_DIV_RST = 12'h0001;
  localparam logic [SR_DIV_W-1:0] SR_DIV_RST = 20'h0_0001;
  localparam logic [DLY_W-1:0]    DLY_RST    = 8'h00;

  typedef enum logic [1:0] {
    ODSM_CMOS_NORMAL,
    ODSM_CMOS_INVERT,
    ODSM_CMOS_HIZ,
    ODSM_CMOS_LOW
  } odsm_cmos_mode_t;

  // Divider index serving each output channel.
  function automatic int odsm_div_of_ch(input int ch);
    if (ch < 4)
      return ch;
    else if (ch < 14)
      return 4 + (ch - 4) / 2;
    else
      return ch - 5;
  endfunction

  // SYSREF slot per divider, or -1 where the cascade is absent.
  function automatic int odsm_sr_of_div(input int d);
    if (d < 2)
      return d;
    else if (d < 4 || d > 8)
      return -1;
    else
      return d - 2;
  endfunction
endpackage

// file: design/odsm_top.sv
// Output divider, SYSREF replication and auto-mute top level.
`timescale 1ns/10ps
// Overview of operation
// - First two channels: 12-bit plus 20-bit divider
// - Pairs 2/3 and 14/15 individual dividers
// - Five middle pairs share one divider
// - Total division: channel times sysref ratio
// - Pair divider off when both drivers disabled
// - Single-channel divider off with driver disabled
// - Static delay, plus SYSREF delays when cascaded
// - CMOS outputs: normal, inverted, high-Z, low
// - CMOS mode only on first two channels
// - GPIO replica needs drive and pair enable
// - Replica tapped after static delay
// - Replica a continuous clock only with cascade on
// - Mute driver while its source is invalid
// - Mute disabled passes output ungated
// - Glitchless synchronous start after lock
// - Sync holds dividers reset, output low
module odsm_top
  import odsm_pkg::*;
(
  input  wire logic                                  clk,
  input  wire logic                                  resetn,
  input  wire logic [odsm_pkg::NUM_SRC-1:0]          analog_lock,
  input  wire logic [odsm_pkg::NUM_SRC-1:0]          digital_lock,
  input  wire logic [odsm_pkg::NUM_SRC-1:0]          digital_phase_lock,
  input  wire logic [odsm_pkg::NUM_SRC-1:0]          mute_on_analog_loop_unlock,
  input  wire logic [odsm_pkg::NUM_SRC-1:0]          mute_on_digital_loop_unlock,
  input  wire logic [odsm_pkg::NUM_SRC-1:0]          mute_on_digital_phase_unlock,
  input  wire logic [odsm_pkg::NUM_DIV-1:0][2:0]     div_source_sel,
  input  wire logic [odsm_pkg::NUM_CH-1:0]           driver_enable,
  input  wire logic [odsm_pkg::NUM_CH-1:0]           mute_enable,
  input  wire logic [odsm_pkg::NUM_DIV-1:0]          div_sync_enable,
  input  wire logic                                  sync_request,
  input  wire logic [odsm_pkg::NUM_DIV-1:0][odsm_pkg::CH_DIV_W-1:0] ch_div,
  input  wire logic [odsm_pkg::NUM_SR-1:0][odsm_pkg::SR_DIV_W-1:0]  sr_div,
  input  wire logic [odsm_pkg::NUM_SR-1:0]           sr_enable,
  input  wire logic [odsm_pkg::NUM_DIV-1:0][odsm_pkg::DLY_W-1:0]    static_dly,
  input  wire logic [odsm_pkg::NUM_SR-1:0][odsm_pkg::DLY_W-1:0]     sr_dly,
  input  wire logic [1:0]                            cmos_enable,
  input  wire odsm_pkg::odsm_cmos_mode_t [3:0]       cmos_mode,
  input  wire logic [1:0]                            gpio_pin_output_drive_enable,
  input  wire logic [odsm_pkg::NUM_SR-1:0]           pair_sysref_replica_enable,
  output logic      [odsm_pkg::NUM_CH-1:0]           out_clk,
  output logic      [odsm_pkg::NUM_CH-1:0]           out_muted,
  output logic      [3:0]                            cmos_out,
  output logic      [3:0]                            cmos_oe,
  output logic      [odsm_pkg::NUM_DIV-1:0]          div_powered,
  output logic      [1:0]                            gpio_out,
  output logic      [1:0]                            gpio_oe
);
  import odsm_pkg::*;

  logic                sync_s1_r;
  logic                sync_s2_r;
  logic [NUM_SRC-1:0]  al_s1_r, al_s2_r, dl_s1_r, dl_s2_r, dp_s1_r, dp_s2_r;
  logic [NUM_SRC-1:0]  src_invalid;
  logic [NUM_DIV-1:0]  div_clk, div_rise, div_tap;
  logic [NUM_CH-1:0]   muted_r, muted_nxt;
  logic [NUM_CH-1:0]   out_r;
  logic                rep_src;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sync_s1_r <= 1'b0;
      sync_s2_r <= 1'b0;
      al_s1_r   <= '0;
      al_s2_r   <= '0;
      dl_s1_r   <= '0;
      dl_s2_r   <= '0;
      dp_s1_r   <= '0;
      dp_s2_r   <= '0;
    end
    else
    begin
      sync_s1_r <= sync_request;
      sync_s2_r <= sync_s1_r;
      al_s1_r   <= analog_lock;
      al_s2_r   <= al_s1_r;
      dl_s1_r   <= digital_lock;
      dl_s2_r   <= dl_s1_r;
      dp_s1_r   <= digital_phase_lock;
      dp_s2_r   <= dp_s1_r;
    end
  end

  assign src_invalid = (mute_on_analog_loop_unlock & ~al_s2_r)
                     | (mute_on_digital_loop_unlock & ~dl_s2_r)
                     | (mute_on_digital_phase_unlock & ~dp_s2_r);

  // ---------------------------------------------------------------
  // Divider instances
  // ---------------------------------------------------------------
  for (genvar d = 0; d < NUM_DIV; d++)
  begin : g_div
    localparam int SR = odsm_sr_of_div(d);
    localparam int C0 = (d < 4) ? d : (d < 9) ? 4 + 2 * (d - 4) : d + 5;
    localparam bit PAIRED = (d >= 4 && d <= 8);
    odsm_div_if dif();

    // Shared divider powered by either driver.
    if (PAIRED)
    begin : g_pair
      assign div_powered[d] = driver_enable[C0] | driver_enable[C0+1];
    end
    else
    begin : g_single
      assign div_powered[d] = driver_enable[C0];
    end

    assign dif.run        = div_powered[d];
    // Sync holds enabled dividers in reset.
    assign dif.sync_hold  = sync_s2_r & div_sync_enable[d];
    assign dif.ch_div     = ch_div[d];
    assign dif.static_dly = static_dly[d];
    if (SR >= 0)
    begin : g_sr
      assign dif.sr_en  = sr_enable[SR];
      assign dif.sr_div = sr_div[SR];
      assign dif.sr_dly = sr_dly[SR];
    end
    else
    begin : g_nosr
      assign dif.sr_en  = 1'b0;
      assign dif.sr_div = SR_DIV_RST;
      assign dif.sr_dly = DLY_RST;
    end

    odsm_divider #(
      .HAS_SR (SR >= 0)
    ) u_div (
      .clk    (clk),
      .resetn (resetn),
      .dif    (dif)
    );
    assign div_clk[d]  = dif.clk_out;
    assign div_rise[d] = dif.rise;
    assign div_tap[d]  = dif.tap;
  end

  // ---------------------------------------------------------------
  // Auto-mute and output drive
  // ---------------------------------------------------------------
  always_comb
  begin
    muted_nxt = muted_r;
    for (int c = 0; c < NUM_CH; c++)
    begin
      int d;
      d = odsm_div_of_ch(c);
      if (!mute_enable[c])
        muted_nxt[c] = 1'b0;
      else if (src_invalid[div_source_sel[d]])
        muted_nxt[c] = 1'b1;
      else if (div_rise[d])
        muted_nxt[c] = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      muted_r <= '1;
    else
      muted_r <= muted_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      out_r <= '0;
    else
      for (int c = 0; c < NUM_CH; c++)
        out_r[c] <= driver_enable[c] && !muted_nxt[c]
                    && div_clk[odsm_div_of_ch(c)];
  end

  assign out_clk   = out_r;
  assign out_muted = muted_r;

  // CMOS pins only on the first two channels.
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      cmos_out[i] = 1'b0;
      cmos_oe[i]  = 1'b0;
      if (cmos_enable[i/2] && driver_enable[i/2])
      begin
        case (cmos_mode[i])
          ODSM_CMOS_NORMAL:
          begin
            cmos_out[i] = out_r[i/2];
            cmos_oe[i]  = 1'b1;
          end
          ODSM_CMOS_INVERT:
          begin
            cmos_out[i] = !out_r[i/2] && !muted_r[i/2];
            cmos_oe[i]  = 1'b1;
          end
          ODSM_CMOS_LOW:
            cmos_oe[i] = 1'b1;
          default:
            cmos_oe[i] = 1'b0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // SYSREF replication onto GPIO
  // ---------------------------------------------------------------
  // First enabled pair drives the replica.
  always_comb
  begin
    rep_src = 1'b0;
    for (int s = NUM_SR - 1; s >= 0; s--)
      if (pair_sysref_replica_enable[s])
        rep_src = div_tap[s < 2 ? s : s + 2];
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      gpio_out <= 2'h0;
    else
      for (int g = 0; g < 2; g++)
        gpio_out[g] <= gpio_pin_output_drive_enable[g]
                       && |pair_sysref_replica_enable && rep_src;
  end

  assign gpio_oe = gpio_pin_output_drive_enable;
endmodule

// file: tb/odsm_properties.sv
// Checker of divider power, mute, sync and CMOS behaviour at the top ports.
`timescale 1ns/10ps
module odsm_properties
  import odsm_pkg::*;
(
  input wire logic                            clk,
  input wire logic                            resetn,
  input wire logic [odsm_pkg::NUM_SRC-1:0]    analog_lock,
  input wire logic [odsm_pkg::NUM_SRC-1:0]    mute_on_analog_loop_unlock,
  input wire logic [odsm_pkg::NUM_DIV-1:0][2:0] div_source_sel,
  input wire logic [odsm_pkg::NUM_CH-1:0]     driver_enable,
  input wire logic [odsm_pkg::NUM_CH-1:0]     mute_enable,
  input wire logic [odsm_pkg::NUM_DIV-1:0]    div_sync_enable,
  input wire logic                            sync_request,
  input wire logic [1:0]                      cmos_enable,
  input wire odsm_pkg::odsm_cmos_mode_t [3:0] cmos_mode,
  input wire logic [1:0]                      gpio_pin_output_drive_enable,
  input wire logic [odsm_pkg::NUM_CH-1:0]     out_clk,
  input wire logic [odsm_pkg::NUM_CH-1:0]     out_muted,
  input wire logic [3:0]                      cmos_oe,
  input wire logic [odsm_pkg::NUM_DIV-1:0]    div_powered,
  input wire logic [1:0]                      gpio_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence lock_lost_s;
    mute_enable[0] && mute_on_analog_loop_unlock[0] && !analog_lock[0]
      && div_source_sel[0] == 3'h0;
  endsequence
  a_single_div_power: assert property (
    div_powered[1:0] == driver_enable[1:0])
    else $error("single divider power wrong");
  a_pair_div_power: assert property (
    div_powered[4] == |driver_enable[5:4])
    else $error("pair divider power wrong");
  a_gpio_oe_drive: assert property (
    gpio_oe == gpio_pin_output_drive_enable)
    else $error("gpio enable wrong");
  a_muted_stays_low: assert property (out_muted[4] |-> !out_clk[4])
    else $error("muted output toggles");
  a_pair_shared_clk: assert property (driver_enable[5:4] == 2'b11
    && out_muted[5:4] == 2'b00 |-> out_clk[4] == out_clk[5])
    else $error("pair outputs differ");
  a_sync_holds_low: assert property ((sync_request
    && div_sync_enable[4])[*6] |-> out_clk[5:4] == 2'b00)
    else $error("sync output not low");
  a_cmos_hiz_off: assert property ((cmos_enable[0]
    && cmos_mode[0] == ODSM_CMOS_HIZ)[*2] |-> !cmos_oe[0])
    else $error("hiz output driven");
  a_unmuted_bypass: assert property ((driver_enable[0]
    && !mute_enable[0] && !sync_request)[*5] |-> !out_muted[0])
    else $error("unmuted gated");
  a_lock_mutes: assert property (lock_lost_s[*5] |-> out_muted[0])
    else $error("lost lock not muted");
endmodule
bind odsm_top odsm_properties odsm_properties_inst (.clk, .resetn,
  .analog_lock, .mute_on_analog_loop_unlock, .div_source_sel, .driver_enable,
  .mute_enable, .div_sync_enable, .sync_request, .cmos_enable, .cmos_mode,
  .gpio_pin_output_drive_enable, .out_clk, .out_muted, .cmos_oe,
  .div_powered, .gpio_oe);

// file: tb/odsm_rx.sv
// Downstream clock receiver that counts rising edges of one output.
`timescale 1ns/10ps
module odsm_rx
(
  input  wire logic clk_in,
  input  wire logic clr,
  output int        edges
);
  // It only listens, so it never loads or drives the output line.
  always @(posedge clk_in or posedge clr)
    if (clr)
      edges <= 0;
    else
      edges <= edges + 1;
endmodule

// file: tb/odsm_top_tb_top.sv
// Self-checking bench for the output divider and mute top level.
`timescale 1ns/10ps
module odsm_top_tb_top;
  import odsm_pkg::*;
  logic clk, resetn, sync_request, clr;
  logic [NUM_SRC-1:0] analog_lock, digital_lock, digital_phase_lock;
  logic [NUM_SRC-1:0] mute_on_analog_loop_unlock, mute_on_digital_loop_unlock;
  logic [NUM_SRC-1:0] mute_on_digital_phase_unlock;
  logic [NUM_DIV-1:0][2:0] div_source_sel;
  logic [NUM_CH-1:0]  driver_enable, mute_enable, out_clk, out_muted;
  logic [NUM_DIV-1:0] div_sync_enable, div_powered;
  logic [NUM_DIV-1:0][CH_DIV_W-1:0] ch_div;
  logic [NUM_SR-1:0][SR_DIV_W-1:0]  sr_div;
  logic [NUM_DIV-1:0][DLY_W-1:0]    static_dly;
  logic [NUM_SR-1:0][DLY_W-1:0]     sr_dly;
  logic [NUM_SR-1:0]  sr_enable, pair_sysref_replica_enable;
  logic [1:0]         cmos_enable, gpio_pin_output_drive_enable;
  odsm_cmos_mode_t [3:0] cmos_mode;
  logic [3:0]         cmos_out, cmos_oe;
  logic [1:0]         gpio_out, gpio_oe;
  int                 mismatches, samples_checked, e0, e4, eg;
  odsm_top odsm_top_inst (.*);
  odsm_rx odsm_rx_inst (.clk_in(out_clk[0]), .clr, .edges(e0));
  odsm_rx odsm_rx_pair (.clk_in(out_clk[4]), .clr, .edges(e4));
  odsm_rx odsm_rx_gpio (.clk_in(gpio_out[0]), .clr, .edges(eg));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic cmp_val(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_cnt(int got, int lo, int hi);
    samples_checked++;
    if (got < lo || got > hi)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask
  // Restarts the receivers, then lets n cycles of output arrive.
  task automatic listen(int n);
    clr = 1'b1;
    #1 clr = 1'b0;
    tick(n);
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic t_power;
    driver_enable = 16'h0010;
    tick(2);
    cmp_val(div_powered[4], 1);
    cmp_val(div_powered[1:0], 0);
    driver_enable = 16'h0000;
    tick(2);
    cmp_val(div_powered[4], 0);
    driver_enable = 16'hffff;
    $display("power test done");
  endtask
  task automatic t_div;
    ch_div[4] = 12'h0003;
    ch_div[0] = 12'h0002;
    sr_div[0] = 20'h0_0003;
    sr_enable[0] = 1'b1;
    tick(40);
    listen(300);
    cmp_cnt(e4, 99, 101);
    cmp_cnt(e0, 49, 51);
    $display("divide test done");
  endtask
  task automatic t_mute;
    for (int k = 0; k < 3; k++)
    begin
      {mute_on_digital_phase_unlock[0], mute_on_digital_loop_unlock[0],
       mute_on_analog_loop_unlock[0]} = 3'b001 << k;
      {digital_phase_lock[0], digital_lock[0], analog_lock[0]} = ~(3'b001 << k);
      tick(8);
      cmp_val(out_muted[0], 1);
      cmp_val(out_clk[0], 0);
      {digital_phase_lock[0], digital_lock[0], analog_lock[0]} = 3'b111;
      tick(40);
      cmp_val(out_muted[0], 0);
    end
    mute_enable[0] = 1'b0;
    digital_phase_lock[0] = 1'b0;
    listen(60);
    cmp_val(out_muted[0], 0);
    cmp_cnt(e0, 9, 11);
    mute_enable[0] = 1'b1;
    digital_phase_lock[0] = 1'b1;
    $display("mute test done");
  endtask
  task automatic t_sync;
    div_sync_enable[4:2] = 3'b111;
    static_dly[3] = 8'h02;
    sync_request = 1'b1;
    tick(10);
    listen(24);
    cmp_cnt(e4, 0, 0);
    sync_request = 1'b0;
    tick(4);
    listen(30);
    cmp_cnt(e4, 9, 11);
    cmp_val(out_clk[3], !out_clk[2]);
    tick(1);
    cmp_val(out_clk[3], !out_clk[2]);
    $display("sync test done");
  endtask
  task automatic t_cmos;
    cmos_enable = 2'b01;
    for (int m = 0; m < 4; m++)
    begin
      cmos_mode[0] = odsm_cmos_mode_t'(m);
      tick(3);
      cmp_val(cmos_oe[0], m != 2);
      if (m == 0)
        cmp_val(cmos_out[0], out_clk[0]);
      if (m == 1)
        cmp_val(cmos_out[0], !out_clk[0]);
      if (m == 3)
        cmp_val(cmos_out[0], 0);
    end
    cmos_enable = 2'b00;
    tick(3);
    cmp_val(cmos_oe, 0);
    $display("cmos test done");
  endtask
  task automatic t_gpio;
    // Slot 0 alone feeds the replica on GPIO 0.
    pair_sysref_replica_enable = 7'h01;
    gpio_pin_output_drive_enable = 2'b01;
    tick(4);
    cmp_val(gpio_oe, 2'b01);
    listen(120);
    cmp_cnt(eg, 19, 21);
    pair_sysref_replica_enable = 7'h00;
    tick(4);
    listen(60);
    cmp_cnt(eg, 0, 0);
    $display("replica test done");
  endtask
  initial
  begin
    resetn = 1'b0;
    clr = 1'b0;
    sync_request = 1'b0;
    {analog_lock, digital_lock, digital_phase_lock} = '1;
    {mute_on_analog_loop_unlock, mute_on_digital_loop_unlock} = '0;
    mute_on_digital_phase_unlock = '0;
    div_source_sel = '0;
    {driver_enable, mute_enable} = '1;
    div_sync_enable = '0;
    ch_div = {NUM_DIV{12'h0004}};
    sr_div = {NUM_SR{20'h0_0002}};
    {static_dly, sr_dly, sr_enable} = '0;
    {cmos_enable, gpio_pin_output_drive_enable} = '0;
    for (int i = 0; i < 4; i++)
      cmos_mode[i] = ODSM_CMOS_NORMAL;
    pair_sysref_replica_enable = '0;
    tick(8);
    cmp_val(out_muted, 16'hffff);
    cmp_val(out_clk, 16'h0000);
    resetn = 1'b1;
    tick(4);
    t_power;
    t_div;
    t_mute;
    t_sync;
    t_cmos;
    t_gpio;
    results;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    results;
  end
endmodule
